//--- fh_bus_cycle.v
`include "fh_defs.vh"
`default_nettype none
module fh_bus_cycle #(
	parameter AW = 21,
	parameter ACC_CYC = `FH_ACC_CYC + `FH_SYNC_CYC,
	parameter WP_CYC = `FH_WP_CYC
) (
	input wire mclk_in,
	input wire srst_in,
	input wire start_in,
	input wire write_in,
	input wire [AW-1:0] addr_in,
	input wire [7:0] wdata_in,
	input wire [7:0] dq_sync_in,
	output reg done_out,
	output reg [7:0] rdata_out,
	output reg [AW-1:0] flash_addr_out,
	output reg [7:0] flash_dq_out,
	output reg flash_dq_oe_out,
	output reg flash_ce_n_out,
	output reg flash_oe_n_out,
	output reg flash_we_n_out
);
	localparam C_IDLE = 2'h0;
	localparam C_SETUP = 2'h1;
	localparam C_PULSE = 2'h2;
	localparam C_HOLD = 2'h3;
	reg [1:0] st_reg;
	reg [7:0] cnt_reg;
	reg wr_reg;
	always @(posedge mclk_in) begin
		if (srst_in) begin
			st_reg <= C_IDLE;
			cnt_reg <= 8'h00;
			wr_reg <= 1'b0;
			done_out <= 1'b0;
			rdata_out <= 8'h00;
			flash_addr_out <= {AW{1'b0}};
			flash_dq_out <= 8'h00;
			flash_dq_oe_out <= 1'b0;
			flash_ce_n_out <= 1'b1;
			flash_oe_n_out <= 1'b1;
			flash_we_n_out <= 1'b1;
		end else begin
			done_out <= 1'b0;
			case (st_reg)
			C_IDLE: begin
				if (start_in) begin
					wr_reg <= write_in;
					flash_addr_out <= addr_in;
					flash_dq_out <= wdata_in;
					flash_dq_oe_out <= write_in;
					flash_ce_n_out <= 1'b0;
					st_reg <= C_SETUP;
				end
			end
			C_SETUP: begin
				if (wr_reg) begin
					flash_we_n_out <= 1'b0;
					cnt_reg <= WP_CYC[7:0];
				end else begin
					flash_oe_n_out <= 1'b0;
					cnt_reg <= ACC_CYC[7:0];
				end
				st_reg <= C_PULSE;
			end
			C_PULSE: begin
				if (cnt_reg == 8'h01) begin
					if (!wr_reg) begin
						rdata_out <= dq_sync_in;
					end
					flash_we_n_out <= 1'b1;
					flash_oe_n_out <= 1'b1;
					st_reg <= C_HOLD;
				end else begin
					cnt_reg <= cnt_reg - 8'h01;
				end
			end
			default: begin
				flash_ce_n_out <= 1'b1;
				flash_dq_oe_out <= 1'b0;
				done_out <= 1'b1;
				st_reg <= C_IDLE;
			end
			endcase
		end
	end
endmodule
`default_nettype wire

//--- fh_defs.vh
`ifndef FH_DEFS_VH
`define FH_DEFS_VH
// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define FH_REG_CTRL 8'h00
`define FH_REG_ADDR 8'h04
`define FH_REG_DATA 8'h08
`define FH_REG_STAT 8'h0C
`define FH_REG_ISTAT 8'h10
`define FH_REG_IMASK 8'h14
`define FH_IDX_CTRL 3'h0
`define FH_IDX_ADDR 3'h1
`define FH_IDX_DATA 3'h2
`define FH_IDX_STAT 3'h3
`define FH_IDX_ISTAT 3'h4
`define FH_IDX_IMASK 3'h5
`define FH_IDX_NONE 3'h7
`define FH_RESP_OKAY 2'h0
`define FH_RESP_SLVERR 2'h2
// ----------------------------------------
// Operation codes written to CTRL
// ----------------------------------------
`define FH_OP_PROG 4'h1
`define FH_OP_SECT 4'h2
`define FH_OP_ADD 4'h3
`define FH_OP_CHIP 4'h4
`define FH_OP_SUSP 4'h5
`define FH_OP_RESUME 4'h6
`define FH_OP_RESET 4'h7
`define FH_OP_POLL 4'h8
// ----------------------------------------
// Flash command bytes and unlock addresses
// ----------------------------------------
`define FH_CMD_UNLK1 8'hAA
`define FH_CMD_UNLK2 8'h55
`define FH_CMD_PROG 8'hA0
`define FH_CMD_ERASE 8'h80
`define FH_CMD_SECT 8'h30
`define FH_CMD_CHIP 8'h10
`define FH_CMD_SUSP 8'hB0
`define FH_CMD_RESUME 8'h30
`define FH_CMD_RESET 8'hF0
`define FH_UNLK_ADDR1 21'h000555
`define FH_UNLK_ADDR2 21'h0002AA
`define FH_ASEL_U1 2'h0
`define FH_ASEL_U2 2'h1
`define FH_ASEL_USER 2'h2
// ----------------------------------------
// Status bit positions on the data bus
// ----------------------------------------
`define FH_BIT_POLLING 7
`define FH_BIT_TOGGLE1 6
`define FH_BIT_TLIMIT 5
`define FH_BIT_WINDOW 3
`define FH_BIT_TOGGLE2 2
// Interrupt bits
`define FH_INT_DONE 0
`define FH_INT_FAIL 1
`define FH_INT_REJ 2
`define FH_INT_W 3
// ----------------------------------------
// Timing
// ----------------------------------------
`define FH_CLK_NS 20
`define FH_ACC_NS 70
`define FH_WP_NS 35
`define FH_ACC_CYC ((`FH_ACC_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_WP_CYC ((`FH_WP_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_SYNC_CYC 2
`endif

//--- fh_host_ctrl.v
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`include "fh_defs.vh"
`default_nettype none
module fh_host_ctrl #(
	parameter AW = 21
) (
	input wire mclk_in,
	input wire srst_in,
	input wire [7:0] axi_awaddr_in,
	input wire axi_awvalid_in,
	output reg axi_awready_out,
	input wire [31:0] axi_wdata_in,
	input wire [3:0] axi_wstrb_in,
	input wire axi_wvalid_in,
	output reg axi_wready_out,
	output reg [1:0] axi_bresp_out,
	output reg axi_bvalid_out,
	input wire axi_bready_in,
	input wire [7:0] axi_araddr_in,
	input wire axi_arvalid_in,
	output reg axi_arready_out,
	output reg [31:0] axi_rdata_out,
	output reg [1:0] axi_rresp_out,
	output reg axi_rvalid_out,
	input wire axi_rready_in,
	output reg irq_out,
	output wire [AW-1:0] flash_addr_out,
	output wire [7:0] flash_dq_out,
	output wire flash_dq_oe_out,
	input wire [7:0] flash_dq_in,
	output wire flash_ce_n_out,
	output wire flash_oe_n_out,
	output wire flash_we_n_out,
	input wire ready_busy_in
);
	// ----------------------------------------
	// Decoding and command sequences
	// ----------------------------------------
	function [2:0] reg_index;
		input [7:0] a;
		begin
			if (a == `FH_REG_CTRL) reg_index = `FH_IDX_CTRL;
			else if (a == `FH_REG_ADDR) reg_index = `FH_IDX_ADDR;
			else if (a == `FH_REG_DATA) reg_index = `FH_IDX_DATA;
			else if (a == `FH_REG_STAT) reg_index = `FH_IDX_STAT;
			else if (a == `FH_REG_ISTAT) reg_index = `FH_IDX_ISTAT;
			else if (a == `FH_REG_IMASK) reg_index = `FH_IDX_IMASK;
			else reg_index = `FH_IDX_NONE;
		end
	endfunction
	// Returns {address select, byte} of step idx of an operation
	function [9:0] seq_word;
		input [3:0] op;
		input [2:0] idx;
		begin
			if (op == `FH_OP_SUSP)
				seq_word = {`FH_ASEL_USER, `FH_CMD_SUSP};
			else if (op == `FH_OP_RESUME)
				seq_word = {`FH_ASEL_USER, `FH_CMD_RESUME};
			else if (op == `FH_OP_RESET)
				seq_word = {`FH_ASEL_USER, `FH_CMD_RESET};
			else if (op == `FH_OP_ADD)
				seq_word = {`FH_ASEL_USER, `FH_CMD_SECT};
			else if (idx == 3'h0 || idx == 3'h3)
				seq_word = {`FH_ASEL_U1, `FH_CMD_UNLK1};
			else if (idx == 3'h1 || idx == 3'h4)
				seq_word = {`FH_ASEL_U2, `FH_CMD_UNLK2};
			else if (op == `FH_OP_PROG && idx == 3'h2)
				seq_word = {`FH_ASEL_U1, `FH_CMD_PROG};
			else if (op == `FH_OP_PROG)
				seq_word = {`FH_ASEL_USER, 8'h00};
			else if (idx == 3'h2)
				seq_word = {`FH_ASEL_U1, `FH_CMD_ERASE};
			else if (op == `FH_OP_CHIP)
				seq_word = {`FH_ASEL_U1, `FH_CMD_CHIP};
			else
				seq_word = {`FH_ASEL_USER, `FH_CMD_SECT};
		end
	endfunction
	function [2:0] seq_last;
		input [3:0] op;
		begin
			if (op == `FH_OP_PROG) seq_last = 3'h3;
			else if (op == `FH_OP_SECT || op == `FH_OP_CHIP)
				seq_last = 3'h5;
			else seq_last = 3'h0;
		end
	endfunction
	// ----------------------------------------
	// Pin synchronisers and bus cycle engine
	// ----------------------------------------
	wire [8:0] pins_sync;
	fh_sync2 #(.W(9)) fh_sync2_inst (
		.mclk_in(mclk_in),
		.srst_in(srst_in),
		.d_in({ready_busy_in, flash_dq_in}),
		.q_out(pins_sync)
	);
	reg cyc_start_reg;
	reg cyc_write_reg;
	reg [AW-1:0] cyc_addr_reg;
	reg [7:0] cyc_wdata_reg;
	wire cyc_done;
	wire [7:0] cyc_rdata;
	fh_bus_cycle #(.AW(AW)) fh_bus_cycle_inst (
		.mclk_in(mclk_in),
		.srst_in(srst_in),
		.start_in(cyc_start_reg),
		.write_in(cyc_write_reg),
		.addr_in(cyc_addr_reg),
		.wdata_in(cyc_wdata_reg),
		.dq_sync_in(pins_sync[7:0]),
		.done_out(cyc_done),
		.rdata_out(cyc_rdata),
		.flash_addr_out(flash_addr_out),
		.flash_dq_out(flash_dq_out),
		.flash_dq_oe_out(flash_dq_oe_out),
		.flash_ce_n_out(flash_ce_n_out),
		.flash_oe_n_out(flash_oe_n_out),
		.flash_we_n_out(flash_we_n_out)
	);
	// ----------------------------------------
	// Registers and bus slave
	// ----------------------------------------
	localparam S_IDLE = 4'h0;
	localparam S_SEQ = 4'h1;
	localparam S_PRE = 4'h2;
	localparam S_ACC_A = 4'h3;
	localparam S_ACC_B = 4'h4;
	localparam S_WIN = 4'h5;
	localparam S_POLL_A = 4'h6;
	localparam S_POLL_B = 4'h7;
	localparam S_RST = 4'h8;
	reg [3:0] st_reg;
	reg [3:0] op_reg;
	reg [AW-1:0] addr_reg;
	reg [7:0] data_reg;
	reg [7:0] last_status_reg;
	reg window_reg;
	reg [`FH_INT_W-1:0] istat_reg;
	reg [`FH_INT_W-1:0] imask_reg;
	reg [`FH_INT_W-1:0] ev_reg;
	reg start_reg;
	reg [7:0] aw_addr_reg;
	reg [31:0] w_data_reg;
	reg [3:0] w_strb_reg;
	wire busy = (st_reg != S_IDLE);
	wire wr_fire = !axi_awready_out && !axi_wready_out && !axi_bvalid_out;
	wire [2:0] wr_idx = reg_index(aw_addr_reg);
	wire [2:0] rd_idx = reg_index(axi_araddr_in);
	reg [31:0] rd_val;
	always @* begin
		rd_val = 32'h00000000;
		case (rd_idx)
		`FH_IDX_CTRL: rd_val = {28'h0000000, op_reg};
		`FH_IDX_ADDR: rd_val = {{(32-AW){1'b0}}, addr_reg};
		`FH_IDX_DATA: rd_val = {24'h000000, data_reg};
		`FH_IDX_STAT: rd_val = {21'h000000, pins_sync[8], window_reg,
			busy, last_status_reg};
		`FH_IDX_ISTAT: rd_val = {29'h00000000, istat_reg};
		`FH_IDX_IMASK: rd_val = {29'h00000000, imask_reg};
		default: rd_val = 32'h00000000;
		endcase
	end
	always @(posedge mclk_in) begin
		if (srst_in) begin
			axi_awready_out <= 1'b1;
			axi_wready_out <= 1'b1;
			axi_bvalid_out <= 1'b0;
			axi_bresp_out <= `FH_RESP_OKAY;
			axi_arready_out <= 1'b1;
			axi_rvalid_out <= 1'b0;
			axi_rresp_out <= `FH_RESP_OKAY;
			axi_rdata_out <= 32'h00000000;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			op_reg <= 4'h0;
			addr_reg <= {AW{1'b0}};
			data_reg <= 8'h00;
			imask_reg <= {`FH_INT_W{1'b0}};
			istat_reg <= {`FH_INT_W{1'b0}};
			start_reg <= 1'b0;
			irq_out <= 1'b0;
		end else begin
			start_reg <= 1'b0;
			if (axi_awready_out && axi_awvalid_in) begin
				aw_addr_reg <= axi_awaddr_in;
				axi_awready_out <= 1'b0;
			end
			if (axi_wready_out && axi_wvalid_in) begin
				w_data_reg <= axi_wdata_in;
				w_strb_reg <= axi_wstrb_in;
				axi_wready_out <= 1'b0;
			end
			if (axi_bvalid_out && axi_bready_in) begin
				axi_bvalid_out <= 1'b0;
				axi_awready_out <= 1'b1;
				axi_wready_out <= 1'b1;
			end
			// Hardware set wins over write-one-to-clear
			istat_reg <= (istat_reg & ~((wr_fire && w_strb_reg[0] &&
				wr_idx == `FH_IDX_ISTAT) ? w_data_reg[`FH_INT_W-1:0] :
				{`FH_INT_W{1'b0}})) | ev_reg;
			irq_out <= |(istat_reg & imask_reg);
			if (wr_fire) begin
				axi_bvalid_out <= 1'b1;
				axi_bresp_out <= `FH_RESP_OKAY;
				if (wr_idx == `FH_IDX_CTRL) begin
					if (busy) begin
						axi_bresp_out <= `FH_RESP_SLVERR;
					end else if (w_strb_reg[0]) begin
						op_reg <= w_data_reg[3:0];
						start_reg <= 1'b1;
					end
				end else if (wr_idx == `FH_IDX_ADDR) begin
					if (w_strb_reg[0]) addr_reg[7:0] <= w_data_reg[7:0];
					if (w_strb_reg[1]) addr_reg[15:8] <= w_data_reg[15:8];
					if (w_strb_reg[2])
						addr_reg[AW-1:16] <= w_data_reg[AW-1:16];
				end else if (wr_idx == `FH_IDX_DATA) begin
					if (w_strb_reg[0]) data_reg <= w_data_reg[7:0];
				end else if (wr_idx == `FH_IDX_IMASK) begin
					if (w_strb_reg[0])
						imask_reg <= w_data_reg[`FH_INT_W-1:0];
				end else if (wr_idx == `FH_IDX_NONE) begin
					axi_bresp_out <= `FH_RESP_SLVERR;
				end
			end
			if (axi_arready_out && axi_arvalid_in) begin
				axi_arready_out <= 1'b0;
				axi_rvalid_out <= 1'b1;
				axi_rdata_out <= rd_val;
				axi_rresp_out <= (rd_idx == `FH_IDX_NONE) ?
					`FH_RESP_SLVERR : `FH_RESP_OKAY;
			end
			if (axi_rvalid_out && axi_rready_in) begin
				axi_rvalid_out <= 1'b0;
				axi_arready_out <= 1'b1;
			end
		end
	end
	// ----------------------------------------
	// Operation sequencer
	// ----------------------------------------
	reg issued_reg;
	reg [2:0] idx_reg;
	reg tog_reg;
	reg recheck_reg;
	reg fail_reg;
	wire [9:0] sw = seq_word(op_reg, idx_reg);
	wire [AW-1:0] seq_addr = (sw[9:8] == `FH_ASEL_U1) ? `FH_UNLK_ADDR1 :
		(sw[9:8] == `FH_ASEL_U2) ? `FH_UNLK_ADDR2 : addr_reg;
	wire is_prog_data = (op_reg == `FH_OP_PROG) && (idx_reg == 3'h3);
	wire st_write = (st_reg == S_SEQ) || (st_reg == S_RST);
	wire [7:0] st_wdata = (st_reg == S_RST) ? `FH_CMD_RESET :
		(is_prog_data ? data_reg : sw[7:0]);
	wire [AW-1:0] st_addr = (st_reg == S_SEQ) ? seq_addr : addr_reg;
	always @(posedge mclk_in) begin
		if (srst_in) begin
			st_reg <= S_IDLE;
			issued_reg <= 1'b0;
			idx_reg <= 3'h0;
			tog_reg <= 1'b0;
			recheck_reg <= 1'b0;
			fail_reg <= 1'b0;
			window_reg <= 1'b0;
			last_status_reg <= 8'h00;
			ev_reg <= {`FH_INT_W{1'b0}};
			cyc_start_reg <= 1'b0;
			cyc_write_reg <= 1'b0;
			cyc_addr_reg <= {AW{1'b0}};
			cyc_wdata_reg <= 8'h00;
		end else begin
			cyc_start_reg <= 1'b0;
			ev_reg <= {`FH_INT_W{1'b0}};
			if (busy && !issued_reg && !cyc_start_reg) begin
				cyc_start_reg <= 1'b1;
				cyc_write_reg <= st_write;
				cyc_addr_reg <= st_addr;
				cyc_wdata_reg <= st_wdata;
				issued_reg <= 1'b1;
			end
			if (cyc_done) begin
				issued_reg <= 1'b0;
				if (!st_write) last_status_reg <= cyc_rdata;
			end
			case (st_reg)
			S_IDLE: begin
				idx_reg <= 3'h0;
				recheck_reg <= 1'b0;
				fail_reg <= 1'b0;
				if (start_reg) begin
					if (op_reg == `FH_OP_ADD)
						st_reg <= S_PRE;
					else if (op_reg == `FH_OP_POLL)
						st_reg <= S_POLL_A;
					else if (op_reg >= `FH_OP_PROG &&
						op_reg <= `FH_OP_RESET)
						st_reg <= S_SEQ;
					else
						ev_reg[`FH_INT_REJ] <= 1'b1;
				end
			end
			S_SEQ: if (cyc_done) begin
				idx_reg <= idx_reg + 3'h1;
				if (idx_reg == seq_last(op_reg)) begin
					if (op_reg == `FH_OP_SECT || op_reg == `FH_OP_ADD)
						st_reg <= S_ACC_A;
					else if (op_reg == `FH_OP_PROG ||
						op_reg == `FH_OP_CHIP)
						st_reg <= S_POLL_A;
					else begin
						ev_reg[`FH_INT_DONE] <= 1'b1;
						st_reg <= S_IDLE;
					end
				end
			end
			S_PRE: if (cyc_done) begin
				window_reg <= cyc_rdata[`FH_BIT_WINDOW];
				// Window closed: erase already running
				if (cyc_rdata[`FH_BIT_WINDOW]) begin
					ev_reg[`FH_INT_REJ] <= 1'b1;
					st_reg <= S_IDLE;
				end else begin
					st_reg <= S_SEQ;
				end
			end
			S_ACC_A: if (cyc_done) begin
				tog_reg <= cyc_rdata[`FH_BIT_TOGGLE1];
				st_reg <= S_ACC_B;
			end
			S_ACC_B: if (cyc_done) begin
				// Toggling means the sequence was taken
				if (tog_reg != cyc_rdata[`FH_BIT_TOGGLE1]) begin
					st_reg <= S_WIN;
				end else begin
					ev_reg[`FH_INT_REJ] <= 1'b1;
					st_reg <= S_IDLE;
				end
			end
			S_WIN: if (cyc_done) begin
				window_reg <= cyc_rdata[`FH_BIT_WINDOW];
				// High after an added sector: maybe not taken
				if (op_reg == `FH_OP_ADD && cyc_rdata[`FH_BIT_WINDOW])
					ev_reg[`FH_INT_REJ] <= 1'b1;
				ev_reg[`FH_INT_DONE] <= 1'b1;
				st_reg <= S_IDLE;
			end
			S_POLL_A: if (cyc_done) begin
				tog_reg <= cyc_rdata[`FH_BIT_TOGGLE1];
				st_reg <= S_POLL_B;
			end
			S_POLL_B: if (cyc_done) begin
				if (tog_reg == cyc_rdata[`FH_BIT_TOGGLE1]) begin
					ev_reg[`FH_INT_DONE] <= 1'b1;
					st_reg <= S_IDLE;
				end else if (recheck_reg) begin
					fail_reg <= 1'b1;
					st_reg <= S_RST;
				end else begin
					recheck_reg <= cyc_rdata[`FH_BIT_TLIMIT];
					st_reg <= S_POLL_A;
				end
			end
			S_RST: if (cyc_done) begin
				ev_reg[`FH_INT_FAIL] <= fail_reg;
				ev_reg[`FH_INT_DONE] <= 1'b1;
				st_reg <= S_IDLE;
			end
			default: st_reg <= S_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

//--- fh_host_ctrl_props.sv
`default_nettype none
module fh_host_ctrl_props #(
	parameter AW = 21
) (
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic axi_bvalid_out,
	input wire logic axi_bready_in,
	input wire logic [1:0] axi_bresp_out,
	input wire logic axi_rvalid_out,
	input wire logic axi_rready_in,
	input wire logic [31:0] axi_rdata_out,
	input wire logic [AW-1:0] flash_addr_out,
	input wire logic flash_dq_oe_out,
	input wire logic flash_ce_n_out,
	input wire logic flash_oe_n_out,
	input wire logic flash_we_n_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (srst_in);
	// ----
	// Flash bus framing and AXI response hold
	// ----
	sequence s_wpulse;
		!flash_we_n_out[*2] ##1 flash_we_n_out;
	endsequence
	sequence s_rpulse;
		!flash_oe_n_out[*6] ##1 flash_oe_n_out;
	endsequence
	a_write_pulse: assert property ($fell(flash_we_n_out) |-> s_wpulse)
		else $error("write strobe width wrong");
	a_read_pulse: assert property ($fell(flash_oe_n_out) |-> s_rpulse)
		else $error("read strobe width wrong");
	a_strobe_in_ce: assert property ((!flash_we_n_out || !flash_oe_n_out)
		|-> !flash_ce_n_out && (flash_we_n_out || flash_oe_n_out))
		else $error("strobe outside select or both low");
	a_no_contend: assert property (flash_dq_oe_out |-> flash_oe_n_out)
		else $error("data driven during read");
	a_write_frame: assert property ($fell(flash_ce_n_out) && flash_dq_oe_out
		|=> $fell(flash_we_n_out))
		else $error("write strobe late");
	a_addr_hold: assert property (!flash_ce_n_out
		&& !$past(flash_ce_n_out) |-> $stable(flash_addr_out))
		else $error("address moved in cycle");
	a_ce_gap: assert property ($rose(flash_ce_n_out) |=> flash_ce_n_out)
		else $error("no idle gap");
	a_b_hold: assert property (axi_bvalid_out && !axi_bready_in
		|=> axi_bvalid_out && $stable(axi_bresp_out))
		else $error("write response dropped");
	a_r_hold: assert property (axi_rvalid_out && !axi_rready_in
		|=> axi_rvalid_out && $stable(axi_rdata_out))
		else $error("read data dropped");
endmodule
bind fh_host_ctrl fh_host_ctrl_props #(.AW(AW)) fh_host_ctrl_props_inst (
	.mclk_in(mclk_in), .srst_in(srst_in), .axi_bvalid_out(axi_bvalid_out),
	.axi_bready_in(axi_bready_in), .axi_bresp_out(axi_bresp_out),
	.axi_rvalid_out(axi_rvalid_out), .axi_rready_in(axi_rready_in),
	.axi_rdata_out(axi_rdata_out), .flash_addr_out(flash_addr_out),
	.flash_dq_oe_out(flash_dq_oe_out), .flash_ce_n_out(flash_ce_n_out),
	.flash_oe_n_out(flash_oe_n_out), .flash_we_n_out(flash_we_n_out)
);
`default_nettype wire

//--- fh_sync2.v
`default_nettype none
module fh_sync2 #(
	parameter W = 8
) (
	input wire mclk_in,
	input wire srst_in,
	input wire [W-1:0] d_in,
	output wire [W-1:0] q_out
);
	reg [W-1:0] s1_reg;
	reg [W-1:0] s2_reg;
	always @(posedge mclk_in) begin
		if (srst_in) begin
			s1_reg <= {W{1'b0}};
			s2_reg <= {W{1'b0}};
		end else begin
			s1_reg <= d_in;
			s2_reg <= s1_reg;
		end
	end
	assign q_out = s2_reg;
endmodule
`default_nettype wire

//--- flash_model.sv
`default_nettype none
module flash_model #(
	parameter int PROG_CYC = 40,
	parameter int WIN_CYC = 320,
	parameter int ERASE_CYC = 600
) (
	input wire logic clk_in,
	input wire logic [7:0] dq_in,
	input wire logic ce_n_in,
	input wire logic oe_n_in,
	input wire logic we_n_in,
	output logic [7:0] dq_out,
	output logic rdy_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// Modes: 0 read, 1 prog, 2 window, 3 erase, 4 suspend, 5 chip
	// ----
	int mode = 0, step = 0, cnt = 0;
	logic tl = 0, tog = 0, tog2 = 0, we_q = 1, oe_q = 1, bad = 0;
	logic [7:0] arr = 8'hFF, pd = 8'h00, st, last = 8'h00;
	always_comb begin
		case (mode)
			1: st = {~pd[7], tog, tl, 5'h00};
			2: st = {1'b0, tog, 3'h0, tog2, 2'h0};
			3, 5: st = {1'b0, tog, tl, 2'b01, tog2, 2'h0};
			4: st = {1'b1, tog, 3'h0, tog2, 2'h0};
			default: st = arr;
		endcase
	end
	// Released bus shows the inverse of the last byte
	assign dq_out = (!ce_n_in && !oe_n_in) ? st : ~last;
	assign rdy_out = (mode == 0 || mode == 4);
	always @(posedge clk_in) begin
		we_q <= we_n_in;
		oe_q <= oe_n_in;
		if (!ce_n_in && !oe_n_in)
			last <= st;
		if (oe_q && !oe_n_in && !ce_n_in) begin
			if (mode != 0 && mode != 4)
				tog <= ~tog;
			if (mode >= 2)
				tog2 <= ~tog2;
		end
		if (cnt > 0 && mode != 4)
			cnt <= cnt - 1;
		if (cnt == 1 && mode != 4) begin
			if (mode == 2) begin
				mode <= 3;
				cnt <= ERASE_CYC;
			end else if (mode == 1 && bad) begin
				tl <= 1'b1;
			end else begin
				arr <= (mode == 1) ? (arr & pd) : 8'hFF;
				mode <= 0;
			end
		end
		if (!we_q && we_n_in && !ce_n_in) begin
			step <= 0;
			if (dq_in == 8'hF0 && (tl || mode == 0)) begin
				mode <= 0;
				tl <= 1'b0;
				cnt <= 0;
			end else if (mode == 2 && dq_in == 8'h30) begin
				cnt <= WIN_CYC;
			end else if ((mode == 3 || mode == 5) && dq_in == 8'hB0) begin
				mode <= 4;
			end else if (mode == 4 && dq_in == 8'h30) begin
				mode <= 3;
			end else if (mode == 0) begin
				case (step)
					0, 3: step <= (dq_in == 8'hAA) ? step + 1 : 0;
					1, 4: step <= (dq_in == 8'h55) ? step + 1 : 0;
					2: step <= (dq_in == 8'hA0) ? 7 : (dq_in == 8'h80) ? 3 : 0;
					5: begin
						mode <= (dq_in == 8'h30) ? 2 : (dq_in == 8'h10) ? 5 : 0;
						cnt <= (dq_in == 8'h30) ? WIN_CYC : ERASE_CYC;
					end
					7: begin
						pd <= dq_in;
						bad <= |(~arr & dq_in);
						mode <= 1;
						cnt <= PROG_CYC;
					end
					default: step <= 0;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

//--- flash_write_status_reporting_bench.sv
`default_nettype none
module flash_write_status_reporting_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_in = 0, srst_in = 1;
	logic [7:0] aw_addr = 0, ar_addr = 0, dq_bus, mdq, fdq, d;
	logic [31:0] w_data = 0, rdata, s, t, fa;
	logic aw_v = 0, w_v = 0, b_rdy = 0, ar_v = 0, r_rdy = 0;
	logic awready, wready, bvalid, arready, rvalid, irq, dq_oe;
	logic ce_n, oe_n, we_n, rdy;
	logic [1:0] bresp, rresp, rr;
	logic [20:0] faddr;
	int miscompares = 0, checks_done = 0, cyc = 0;
	always #10 mclk_in = ~mclk_in;
	assign dq_bus = dq_oe ? fdq : mdq;
	fh_host_ctrl fh_host_ctrl_inst (
		.mclk_in(mclk_in), .srst_in(srst_in),
		.axi_awaddr_in(aw_addr), .axi_awvalid_in(aw_v),
		.axi_awready_out(awready), .axi_wdata_in(w_data),
		.axi_wstrb_in(4'hF), .axi_wvalid_in(w_v), .axi_wready_out(wready),
		.axi_bresp_out(bresp), .axi_bvalid_out(bvalid), .axi_bready_in(b_rdy),
		.axi_araddr_in(ar_addr), .axi_arvalid_in(ar_v),
		.axi_arready_out(arready), .axi_rdata_out(rdata),
		.axi_rresp_out(rresp), .axi_rvalid_out(rvalid),
		.axi_rready_in(r_rdy), .irq_out(irq), .flash_addr_out(faddr),
		.flash_dq_out(fdq), .flash_dq_oe_out(dq_oe), .flash_dq_in(dq_bus),
		.flash_ce_n_out(ce_n), .flash_oe_n_out(oe_n),
		.flash_we_n_out(we_n), .ready_busy_in(rdy)
	);
	flash_model flash_model_inst (
		.clk_in(mclk_in), .dq_in(dq_bus), .ce_n_in(ce_n), .oe_n_in(oe_n),
		.we_n_in(we_n), .dq_out(mdq), .rdy_out(rdy)
	);
	// ----
	// Bus tasks and checks
	// ----
	function automatic logic [31:0] prog_exp(input logic [7:0] o, n);
		return {30'h0, |(~o & n), 1'b1};
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] v,
			input logic [1:0] er);
		logic ga, gw;
		ga = 0;
		gw = 0;
		aw_addr <= a;
		w_data <= v;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_rdy <= 1'b1;
		while (!(ga && gw)) begin
			@(posedge mclk_in);
			if (awready && !ga)
				aw_v <= 1'b0;
			if (wready && !gw)
				w_v <= 1'b0;
			ga = ga | awready;
			gw = gw | wready;
		end
		do @(posedge mclk_in); while (bvalid !== 1'b1);
		chk(bresp, er);
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] v,
			output logic [1:0] r);
		ar_addr <= a;
		ar_v <= 1'b1;
		r_rdy <= 1'b1;
		do @(posedge mclk_in); while (arready !== 1'b1);
		ar_v <= 1'b0;
		do @(posedge mclk_in); while (rvalid !== 1'b1);
		v = rdata;
		r = rresp;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] m, e);
		axr(a, t, rr);
		chk(t & m, e);
	endtask
	task automatic wdone(output logic [31:0] v);
		do @(posedge mclk_in); while (irq !== 1'b1);
		axr(8'h10, v, rr);
		axw(8'h10, v, 2'h0);
	endtask
	task automatic run(input logic [3:0] o, output logic [31:0] v);
		axw(8'h00, {28'h0, o}, 2'h0);
		wdone(v);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge mclk_in) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			miscompares++;
			$display("MISMATCH %0t: timeout", $time);
			end_of_test();
		end
	end
	initial begin
		void'($urandom(86));
		repeat (6) @(posedge mclk_in);
		srst_in <= 1'b0;
		@(posedge mclk_in);
		rchk(8'h10, 32'hFFFFFFFF, 32'h0);
		rchk(8'h14, 32'hFFFFFFFF, 32'h0);
		axr(8'h18, t, rr);
		chk(rr, 2'h2);
		chk(t, 32'h0);
		axw(8'h18, 32'h1, 2'h2);
		axw(8'h00, 32'h0, 2'h0);
		repeat (4) @(posedge mclk_in);
		chk(irq, 1'b0);
		rchk(8'h10, 32'h7, 32'h4);
		axw(8'h10, 32'h4, 2'h0);
		axw(8'h14, 32'h5, 2'h0);
		rchk(8'h10, 32'h7, 32'h0);
		chk(irq, 1'b0);
		$display("test registers done");
		d = 8'($urandom() & 32'h7F);
		fa = $urandom() & 32'h1FFFFF;
		axw(8'h04, fa, 2'h0);
		axw(8'h08, {24'h0, d}, 2'h0);
		run(4'h1, s);
		chk(s & 32'h7, prog_exp(8'hFF, d));
		chk(flash_model_inst.arr, d);
		chk(faddr, fa);
		rchk(8'h0C, 32'h400, 32'h400);
		axw(8'h08, 32'h80, 2'h0);
		run(4'h1, s);
		chk(s & 32'h7, prog_exp(d, 8'h80));
		chk(flash_model_inst.mode, 0);
		rchk(8'h0C, 32'h400, 32'h400);
		$display("test program done");
		axw(8'h00, 32'h2, 2'h0);
		axw(8'h00, 32'h8, 2'h2);
		wdone(s);
		chk(s & 32'h7, 32'h1);
		rchk(8'h0C, 32'h600, 32'h0);
		repeat (200) @(posedge mclk_in);
		run(4'h3, s);
		chk(s & 32'h7, 32'h1);
		repeat (200) @(posedge mclk_in);
		run(4'h3, s);
		chk(s & 32'h7, 32'h1);
		repeat (450) @(posedge mclk_in);
		run(4'h3, s);
		chk(s & 32'h4, 32'h4);
		rchk(8'h0C, 32'h400, 32'h0);
		run(4'h5, s);
		rchk(8'h0C, 32'h400, 32'h400);
		chk(flash_model_inst.mode, 4);
		run(4'h6, s);
		run(4'h8, s);
		chk(s & 32'h7, 32'h1);
		chk(flash_model_inst.arr, 8'hFF);
		$display("test sector erase done");
		run(4'h4, s);
		chk(s & 32'h7, 32'h1);
		rchk(8'h0C, 32'h400, 32'h400);
		$display("test chip erase done");
		end_of_test();
	end
endmodule
`default_nettype wire
